// ===== include/cbq_pkg.sv
package cbq_pkg;

  // table locations as printed (not multiples of four: each is an index, byte address = 4*index)
  localparam logic [9:0] IDX_BURST_FIELD_COUNT     = 10'h128;
  localparam logic [9:0] IDX_BURST_CAP_FIRST       = 10'h129;
  localparam logic [9:0] IDX_BURST_CAP_SECOND      = 10'h12a;
  localparam logic [9:0] IDX_BURST_CAP_THIRD       = 10'h12b;
  localparam logic [9:0] IDX_BURST_CAP_FOURTH      = 10'h12c;
  localparam logic [9:0] IDX_PARTITION_REGION_CNT  = 10'h12d;
  localparam logic [9:0] IDX_REGION_INFO_SIZE_LO   = 10'h12e;
  localparam logic [9:0] IDX_REGION_INFO_SIZE_HI   = 10'h12f;
  localparam logic [9:0] IDX_IDENT_PARTITIONS_LO   = 10'h130;
  localparam logic [9:0] IDX_IDENT_PARTITIONS_HI   = 10'h131;
  localparam logic [9:0] IDX_OPS_IN_PARTITION      = 10'h132;
  localparam logic [9:0] IDX_OPS_DURING_PROGRAM    = 10'h133;
  localparam logic [9:0] IDX_OPS_DURING_ERASE      = 10'h134;
  localparam logic [9:0] IDX_ERASE_REGION_TYPES    = 10'h135;
  localparam logic [9:0] IDX_TYPE1_BLOCK_COUNT_LO  = 10'h136;
  localparam logic [9:0] IDX_TYPE1_BLOCK_COUNT_HI  = 10'h137;
  localparam logic [9:0] IDX_TYPE1_BLOCK_SIZE_LO   = 10'h138;
  localparam logic [9:0] IDX_TYPE1_BLOCK_SIZE_HI   = 10'h139;

  // fixed contents
  localparam logic [7:0] VAL_BURST_FIELD_COUNT   = 8'h04;
  localparam logic [2:0] CODE_BURST_4            = 3'h1;
  localparam logic [2:0] CODE_BURST_8            = 3'h2;
  localparam logic [2:0] CODE_BURST_16           = 3'h3;
  localparam logic [2:0] CODE_BURST_CONTINUOUS   = 3'h7;
  localparam logic [7:0] VAL_PARTITION_REGIONS   = 8'h01;
  localparam logic [15:0] VAL_REGION_INFO_SIZE   = 16'h0000 + 16'h0000;
  localparam logic [15:0] VAL_IDENT_PARTITIONS   = 16'h0001;
  localparam logic [3:0] VAL_PART_PROG_OPS       = 4'h1;
  localparam logic [3:0] VAL_PART_ERASE_OPS      = 4'h1;
  localparam logic [3:0] VAL_PROG_OTHER_PROG     = 4'h1;
  localparam logic [3:0] VAL_PROG_OTHER_ERASE    = 4'h1;
  localparam logic [3:0] VAL_ERASE_OTHER_PROG    = 4'h1;
  localparam logic [3:0] VAL_ERASE_OTHER_ERASE   = 4'h1;
  localparam logic [7:0] VAL_ERASE_REGION_TYPES  = 8'h01;
  localparam logic [15:0] VAL_TYPE1_BLOCKS_M1    = 16'h01ff;
  localparam logic [15:0] VAL_TYPE1_SIZE_256     = 16'h0200;
  localparam logic [15:0] VAL_REGION_DESC_LOCS   = 16'h0020;

  localparam logic [31:0] RESET_RDATA = 32'h0000_0000;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic        pending;
    logic [31:0] rdata;
  } cbq_state_s;

endpackage : cbq_pkg

// ===== core/cbq_query_rom.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1 - burst codes: bits 2:0 hold n, burst is 2^(n+1) words; bits 7:3 zero
// R2 - code seven means unbounded linear burst to end of burstable space
// R3 - host may copy a code into read-config bits 2:0 at full width
// R4 - first burst location returns 01, four-word burst
// R5 - second burst location returns 02, eight-word burst
// R6 - third burst location returns 03, sixteen-word burst
// R7 - fourth burst location returns 07, continuous burst
// R8 - partition region count; zero would mean single partition, no fields
// R9 - two-location region descriptor size, counting itself
// R10 - two-location count of identical partitions in the region
// R11 - in-partition limits: program ops low nibble, erase ops high nibble
// R12 - other-partition ops while programming, program low, erase high nibble
// R13 - other-partition ops while erasing, program low, erase high nibble
// R14 - erase-block region count; zero means bulk erase only
// R15 - symmetric partition reports exactly one erase-block region
// R16 - type-1 descriptor bits 15:0 hold y, block count is y+1
// R17 - type-1 descriptor bits 31:16 hold z, block size z*256 bytes
// R18 - location before burst codes reports four configuration bytes
// R19 - reads have no side effect and always return the same low byte
module cbq_query_rom (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  // one table slot per location of the slice, in address order
  localparam int unsigned N_ENTRIES = 18;

  cbq_pkg::cbq_state_s  state_r;
  cbq_pkg::cbq_state_s  state_nxt;
  logic [7:0]           rom_byte;
  logic [9:0]           idx;
  // per-slot decode results and fixed bytes
  logic [N_ENTRIES-1:0] hit;
  logic [7:0]           entry_val [N_ENTRIES];

  // word index from the byte address; low two bits ignored for whole words
  // upper address bits are not decoded, so the slice repeats every 4 KB;
  // hsize and hwdata are unused: every access is taken as one whole word
  assign idx = haddr[11:2];

  // table map, by index (byte address is four times the index):
  //   128         number of burst configuration bytes that follow
  //   129 to 12c  burst length codes, shortest first
  //   12d         partition region count
  //   12e to 12f  size of the region descriptor, low byte first
  //   130 to 131  identical partitions in the region
  //   132         limits inside one partition
  //   133         limits on other partitions while one programs
  //   134         limits on other partitions while one erases
  //   135         erase-block region count
  //   136 to 137  type-1 erase block count minus one
  //   138 to 139  type-1 erase block size in 256-byte units
  // reserved bits of every code byte are zero
  // every other index reads zero, so a host probing past the slice sees
  // an empty field rather than stale data

  // number of burst configuration bytes that follow
  // a zero here would tell the host there is no burst support at all
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_BURST_FIELD_COUNT),
    .VAL (cbq_pkg::VAL_BURST_FIELD_COUNT)
  ) u_burst_field_count (
    .idx   (idx),
    .hit   (hit[0]),
    .value (entry_val[0])
  ); // R18

  // shortest burst code; bits 7:3 stay zero
  // the host may copy bits 2:0 straight into its read configuration
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_BURST_CAP_FIRST),
    .VAL ({5'h00, cbq_pkg::CODE_BURST_4})
  ) u_burst_cap_first (
    .idx   (idx),
    .hit   (hit[1]),
    .value (entry_val[1])
  ); // R1 R3 R4

  // second burst code, eight words
  // same layout as the first, only the code differs
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_BURST_CAP_SECOND),
    .VAL ({5'h00, cbq_pkg::CODE_BURST_8})
  ) u_burst_cap_second (
    .idx   (idx),
    .hit   (hit[2]),
    .value (entry_val[2])
  ); // R1 R5

  // third burst code, sixteen words
  // same layout as the first, only the code differs
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_BURST_CAP_THIRD),
    .VAL ({5'h00, cbq_pkg::CODE_BURST_16})
  ) u_burst_cap_third (
    .idx   (idx),
    .hit   (hit[3]),
    .value (entry_val[3])
  ); // R1 R6

  // fourth burst code: all ones in bits 2:0 means an endless linear burst
  // that runs until the burst counter reaches the end of burstable space
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_BURST_CAP_FOURTH),
    .VAL ({5'h00, cbq_pkg::CODE_BURST_CONTINUOUS})
  ) u_burst_cap_fourth (
    .idx   (idx),
    .hit   (hit[4]),
    .value (entry_val[4])
  ); // R1 R2 R7

  // partition region count
  // non-zero, so the region descriptor below is present
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_PARTITION_REGION_CNT),
    .VAL (cbq_pkg::VAL_PARTITION_REGIONS)
  ) u_partition_region_count (
    .idx   (idx),
    .hit   (hit[5]),
    .value (entry_val[5])
  ); // R8

  // descriptor size, low byte
  // counted in locations and including this size field itself
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_REGION_INFO_SIZE_LO),
    .VAL (cbq_pkg::VAL_REGION_DESC_LOCS[7:0])
  ) u_region_info_size_low (
    .idx   (idx),
    .hit   (hit[6]),
    .value (entry_val[6])
  ); // R9

  // descriptor size, high byte
  // split over two locations because each location carries one byte
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_REGION_INFO_SIZE_HI),
    .VAL (cbq_pkg::VAL_REGION_DESC_LOCS[15:8])
  ) u_region_info_size_high (
    .idx   (idx),
    .hit   (hit[7]),
    .value (entry_val[7])
  ); // R9

  // identical partitions in the region, low byte
  // one 16-bit count spread over two locations
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_IDENT_PARTITIONS_LO),
    .VAL (cbq_pkg::VAL_IDENT_PARTITIONS[7:0])
  ) u_identical_partitions_low (
    .idx   (idx),
    .hit   (hit[8]),
    .value (entry_val[8])
  ); // R10

  // identical partitions in the region, high byte
  // upper half of the same count
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_IDENT_PARTITIONS_HI),
    .VAL (cbq_pkg::VAL_IDENT_PARTITIONS[15:8])
  ) u_identical_partitions_high (
    .idx   (idx),
    .hit   (hit[9]),
    .value (entry_val[9])
  ); // R10

  // limits inside one partition
  // program count in the low nibble, erase count in the high nibble
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_OPS_IN_PARTITION),
    .VAL ({cbq_pkg::VAL_PART_ERASE_OPS, cbq_pkg::VAL_PART_PROG_OPS})
  ) u_ops_in_partition (
    .idx   (idx),
    .hit   (hit[10]),
    .value (entry_val[10])
  ); // R11

  // what other partitions may run while one of this region programs
  // program count in the low nibble, erase count in the high nibble
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_OPS_DURING_PROGRAM),
    .VAL ({cbq_pkg::VAL_PROG_OTHER_ERASE, cbq_pkg::VAL_PROG_OTHER_PROG})
  ) u_ops_during_program (
    .idx   (idx),
    .hit   (hit[11]),
    .value (entry_val[11])
  ); // R12

  // what other partitions may run while one of this region erases
  // program count in the low nibble, erase count in the high nibble
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_OPS_DURING_ERASE),
    .VAL ({cbq_pkg::VAL_ERASE_OTHER_ERASE, cbq_pkg::VAL_ERASE_OTHER_PROG})
  ) u_ops_during_erase (
    .idx   (idx),
    .hit   (hit[12]),
    .value (entry_val[12])
  ); // R13

  // erase-block region count
  // the partition is symmetrically blocked, so exactly one region
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_ERASE_REGION_TYPES),
    .VAL (cbq_pkg::VAL_ERASE_REGION_TYPES)
  ) u_erase_region_types (
    .idx   (idx),
    .hit   (hit[13]),
    .value (entry_val[13])
  ); // R14 R15

  // type-1 block count minus one, low byte
  // stored as y so that the full 16-bit range maps to 1 .. 65536 blocks
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_TYPE1_BLOCK_COUNT_LO),
    .VAL (cbq_pkg::VAL_TYPE1_BLOCKS_M1[7:0])
  ) u_type1_block_count_low (
    .idx   (idx),
    .hit   (hit[14]),
    .value (entry_val[14])
  ); // R16

  // type-1 block count minus one, high byte
  // bits 15:8 of the same y
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_TYPE1_BLOCK_COUNT_HI),
    .VAL (cbq_pkg::VAL_TYPE1_BLOCKS_M1[15:8])
  ) u_type1_block_count_high (
    .idx   (idx),
    .hit   (hit[15]),
    .value (entry_val[15])
  ); // R16

  // type-1 block size in 256-byte units, low byte
  // descriptor bits 23:16 of the four-location field
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_TYPE1_BLOCK_SIZE_LO),
    .VAL (cbq_pkg::VAL_TYPE1_SIZE_256[7:0])
  ) u_type1_block_size_low (
    .idx   (idx),
    .hit   (hit[16]),
    .value (entry_val[16])
  ); // R17

  // type-1 block size in 256-byte units, high byte
  // descriptor bits 31:24 of the four-location field
  cbq_rom_entry #(
    .IDX (cbq_pkg::IDX_TYPE1_BLOCK_SIZE_HI),
    .VAL (cbq_pkg::VAL_TYPE1_SIZE_256[15:8])
  ) u_type1_block_size_high (
    .idx   (idx),
    .hit   (hit[17]),
    .value (entry_val[17])
  ); // R17

  // pick the matching slot; indices are distinct, so at most one hit is set
  // and unmapped or reserved positions fall through to zero
  always_comb begin
    rom_byte = 8'h00;
    for (int k = 0; k < N_ENTRIES; k++) begin
      if (hit[k]) begin
        rom_byte = entry_val[k];
      end
    end
  end

  // capture on a valid address phase; writes are accepted and dropped (table is fixed)
  // the byte is latched in the address phase so hrdata is a flip-flop output
  // and stands through the whole data phase with no wait state
  always_comb begin
    state_nxt         = state_r;
    state_nxt.pending = 1'b0;
    if (hsel && hready && htrans[1]) begin
      state_nxt.pending = 1'b1;
      state_nxt.rdata   = hwrite ? 32'h0000_0000 : {24'h00_0000, rom_byte}; // R19
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{pending: 1'b0, rdata: cbq_pkg::RESET_RDATA};
    end else begin
      state_r <= state_nxt;
    end
  end

  // zero wait states, always okay; data comes from a flip-flop
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state_r.rdata;

endmodule : cbq_query_rom

// one table location: flags a match on its own index and carries its fixed byte
// kept as a tiny module so every location is built and checked the same way
module cbq_rom_entry #(
  parameter logic [9:0] IDX = 10'h000,
  parameter logic [7:0] VAL = 8'h00
) (
  input  wire logic [9:0] idx,
  output logic            hit,
  output logic [7:0]      value
);

  // pure decode, no storage: a read never changes anything here
  assign hit = (idx == IDX); // R19

  // the byte is a constant, so repeated reads cannot differ
  assign value = VAL; // R19

endmodule : cbq_rom_entry

// ===== bench/cbq_query_rom_asserts.sv
`timescale 1ns/100ps
module cbq_query_rom_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hrdata,
  input wire logic [1:0]  htrans
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // index of a read taken at this edge, zero when none
  wire [9:0] ix = (hsel && hready && htrans[1] && !hwrite) ? haddr[11:2] : 10'h000;
  wire [7:0] b = hrdata[7:0];
  zero_wait_a: assert property (hreadyout && !hresp) else $error("stall");
  high_zero_a: assert property (hrdata[31:8] == 24'h00_0000) else $error("high");
  hold_idle_a: assert property (!htrans[1] |=> $stable(hrdata)) else $error("drift");
  cap_four_a: assert property (ix == 10'h129 |=> b == 8'h01) else $error("c1");
  cap_eight_a: assert property (ix == 10'h12a |=> b == 8'h02) else $error("c2");
  cap_sixteen_a: assert property (ix == 10'h12b |=> b == 8'h03) else $error("c3");
  cap_endless_a: assert property (ix == 10'h12c |=> b == 8'h07) else $error("c4");
  count_four_a: assert property (ix == 10'h128 |=> b == 8'h04) else $error("cnt");
endmodule : cbq_query_rom_asserts

// ===== bench/cbq_host_model.sv
`timescale 1ns/100ps
module cbq_host_model (
  input  wire logic        clk_sys,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [31:0]      hwdata
);
  initial begin
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
  end
  // one word; waits on ready in both phases, so slow answers are taken too
  task automatic xfer(input logic w, input logic [9:0] i, output logic [31:0] d);
    @(posedge clk_sys);
    htrans <= cbq_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0_0000, i, 2'h0};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= 32'h0000_00ff; // data phase word; the table must ignore it
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer
endmodule : cbq_host_model

// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, hreadyout, hresp;
  logic [31:0] hrdata, d, haddr, hwdata;
  logic [1:0]  htrans;
  logic        hwrite;
  int n_mismatch = 0, checks = 0, cyc = 0;
  // table bytes from index 0x128 upward, lowest byte first
  logic [143:0] tbl = 144'h0200_01ff_0111_1111_0001_0020_0107_0302_0104;
  initial forever #4 clk_sys = ~clk_sys;
  cbq_host_model host (.clk_sys(clk_sys), .hreadyout(hreadyout), .hrdata(hrdata),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
  cbq_query_rom DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) n_mismatch++;
    if (seen !== want) $display("Error hrdata expected %h seen %h", want, seen);
  endtask : chk
  task automatic finish_test(input int extra);
    n_mismatch += extra;
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***"); else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // hang guard, far past the roughly 120 cycles needed
  always @(posedge clk_sys) if (++cyc == 3000) finish_test(1);
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int p = 0; p < 2; p++) for (int i = 0; i < 18; i++) begin
      host.xfer(1'b0, 10'h128 + 10'(i), d);
      chk(d, {24'h00_0000, tbl[8*i +: 8]});
    end
    // a write must leave the fixed contents alone
    host.xfer(1'b1, 10'h135, d);
    chk(d, 32'h0000_0000);
    host.xfer(1'b0, 10'h135, d);
    chk(d, 32'h0000_0001);
    host.xfer(1'b0, 10'h000, d);
    chk(d, 32'h0000_0000);
    finish_test(0);
  end
endmodule : tb_top
bind cbq_query_rom cbq_query_rom_asserts u_chk (.*);
